// ==== logic/isprg_defs.svh ====
/*
 * constants of the in-system flash programming register block: register
 * byte offsets, reset values, field positions, boot vectors, timing.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef ISPRG_DEFS_SVH
`define ISPRG_DEFS_SVH

// ********************
// register byte offsets (one aligned word each)
// ********************
`define ISPRG_OFF_ADDR_HIGH    8'h00
`define ISPRG_OFF_ADDR_LOW     8'h04
`define ISPRG_OFF_READ_DATA    8'h08
`define ISPRG_OFF_WRITE_DATA   8'h0c
`define ISPRG_OFF_PULSE_TIMING 8'h10
`define ISPRG_OFF_COMMAND      8'h14
`define ISPRG_OFF_STATUS       8'h18

// ********************
// reset values and fields
// ********************
`define ISPRG_ADDR_RESET       8'h00
`define ISPRG_TIMING_RESET     8'h7b
`define ISPRG_TIMING_WR_MASK   8'h7f
`define ISPRG_UNMAPPED_DATA    32'hdeadbeef
`define ISPRG_CMD_READ         2'h0
`define ISPRG_CMD_WRITE        2'h1
`define ISPRG_CMD_PAGE_ERASE   2'h2
`define ISPRG_CMD_MASS_ERASE   2'h3
`define ISPRG_STAT_BUSY        0
`define ISPRG_STAT_BOOT_ROM    1

// ********************
// addresses
// ********************
`define ISPRG_MASS_ERASE_ADDR  16'h0000
`define ISPRG_OPTION_ALIAS     16'hffff
`define ISPRG_OPTION_ADDR      16'h1fff
`define ISPRG_RESET_VECTOR     16'h0000
`define ISPRG_BOOT_ROM_BYTES   1024

// ********************
// timing: pulse length per timing-code step
// ********************
`define ISPRG_CLK_MHZ          250
`define ISPRG_STEP_NS          40
`define ISPRG_STEP_CYCLES      ((`ISPRG_STEP_NS * `ISPRG_CLK_MHZ + 999) / 1000)

`endif

// ==== logic/isprg_pkg.sv ====
/*
 * types shared by the programming register block and its submodules.
 * assumes the defs header supplies all numeric constants.
 */
package isprg_pkg;

   typedef enum logic [1:0] {
      ISPRG_OP_READ,
      ISPRG_OP_WRITE,
      ISPRG_OP_PAGE_ERASE,
      ISPRG_OP_MASS_ERASE
   } isprg_op_e;

   typedef enum logic [1:0] {
      ISPRG_ST_IDLE,
      ISPRG_ST_REQ,
      ISPRG_ST_PULSE
   } isprg_state_e;

endpackage

// ==== logic/isprg_flash_if.sv ====
/*
 * carrier between the register block and its flash sequencer.
 * assumes one clock domain, the same as the register block.
 */
`timescale 1ns/1ps

interface isprg_flash_if;
   logic                    start;
   isprg_pkg::isprg_op_e    op;
   logic [15:0]             addr;
   logic [7:0]              wdata;
   logic [7:0]              timing;
   logic                    busy;
   logic                    done;
   logic [7:0]              rdata;

   modport ctrl (output start, output op, output addr, output wdata, output timing,
                 input busy, input done, input rdata);
   modport seq  (input start, input op, input addr, input wdata, input timing,
                 output busy, output done, output rdata);
endinterface

// ==== logic/isprg_sequencer.sv ====
/*
 * flash operation sequencer: issues one read, write or erase on the
 * flash array port and times the pulse from the timing code.
 * assumes the flash array acknowledges each request with flashAck.
 */
`timescale 1ns/1ps
`include "isprg_defs.svh"

module isprg_sequencer (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // register side
   isprg_flash_if.seq        fl,
   // flash array
   output logic              flashReq,
   output isprg_pkg::isprg_op_e flashOp,
   output logic [15:0]       flashAddr,
   output logic [7:0]        flashWdata,
   output logic              flashPulse,
   input  wire logic         flashAck,
   input  wire logic [7:0]   flashRdata
);

   isprg_pkg::isprg_state_e  state;
   logic [15:0]              pulseLeft;
   logic [7:0]               stepLeft;

   assign fl.busy = (state != isprg_pkg::ISPRG_ST_IDLE);

   // ************************************************************
   // sequence
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state      <= isprg_pkg::ISPRG_ST_IDLE;
         flashReq   <= 1'b0;
         flashPulse <= 1'b0;
         flashOp    <= isprg_pkg::ISPRG_OP_READ;
         flashAddr  <= 16'h0000;
         flashWdata <= 8'h00;
         pulseLeft  <= 16'h0000;
         stepLeft   <= 8'h00;
         fl.done    <= 1'b0;
      end else begin
         fl.done <= 1'b0;
         case (state)
            isprg_pkg::ISPRG_ST_IDLE: begin
               if (fl.start) begin
                  flashReq   <= 1'b1;
                  flashOp    <= fl.op;
                  flashAddr  <= fl.addr;
                  flashWdata <= fl.wdata;
                  state      <= isprg_pkg::ISPRG_ST_REQ;
               end
            end
            isprg_pkg::ISPRG_ST_REQ: begin
               if (flashAck) begin
                  flashReq <= 1'b0;
                  if (flashOp == isprg_pkg::ISPRG_OP_READ) begin
                     fl.done <= 1'b1;
                     state   <= isprg_pkg::ISPRG_ST_IDLE;
                  end else begin
                     flashPulse <= 1'b1;
                     pulseLeft  <= {9'h000, fl.timing[6:0]};
                     stepLeft   <= 8'(`ISPRG_STEP_CYCLES - 1);
                     state      <= isprg_pkg::ISPRG_ST_PULSE;
                  end
               end
            end
            isprg_pkg::ISPRG_ST_PULSE: begin
               if (stepLeft != 8'h00) begin
                  stepLeft <= stepLeft - 8'h01;
               end else if (pulseLeft != 16'h0000) begin
                  pulseLeft <= pulseLeft - 16'h0001;
                  stepLeft  <= 8'(`ISPRG_STEP_CYCLES - 1);
               end else begin
                  flashPulse <= 1'b0;
                  fl.done    <= 1'b1;
                  state      <= isprg_pkg::ISPRG_ST_IDLE;
               end
            end
            default: state <= isprg_pkg::ISPRG_ST_IDLE;
         endcase
      end
   end

   // ************************************************************
   // read capture
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (state == isprg_pkg::ISPRG_ST_REQ && flashAck) begin
         fl.rdata <= flashRdata;
      end
   end

endmodule

// ==== logic/isprg_boot_select.sv ====
/*
 * boot source choice: samples the option bit each clock while reset is high, holds it after release
 * and gives the fetch start point.
 * assumes the option bit is valid while reset is high.
 */
`timescale 1ns/1ps
`include "isprg_defs.svh"

module isprg_boot_select (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // option bit
   input  wire logic         bootFromFlash,
   // result
   output logic              runBootRom,
   output logic [15:0]       startAddr,
   output logic              startValid
);

   // caught by a clocked process during reset, never as a reset value
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // set bit starts flash at 0000
         runBootRom <= ~bootFromFlash;
         startAddr  <= `ISPRG_RESET_VECTOR;
         startValid <= 1'b0;
      end else begin
         startValid <= 1'b1;
      end
   end

endmodule

// ==== logic/isprg_regs.sv ====
/*
 * in-system flash programming register block: avalon-mm slave holding
 * address, data and pulse-timing registers, a command port that starts
 * flash operations, and the boot source choice at reset exit.
 * assumes a single 250 mhz clock, synchronous reset, and a flash array
 * port that acknowledges each request.
 */
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "isprg_defs.svh"

// What this block does
// - option bit zero boots from rom
// - option bit one starts flash 0000
// - address is high and low bytes
// - alias ffff reaches option byte 1fff
// - address registers reset to 00
// - read result lands in read data
// - write byte comes from write data
// - pulse width follows timing code
// - timing resets to 10 mhz code
// - timing bit 7 read only
// - hidden control not software visible
// - boot rom is 1k bytes
// - rom boot watches serial port
module isprg_regs #(
   parameter int BOOT_ROM_BYTES = `ISPRG_BOOT_ROM_BYTES
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // avalon-mm slave
   input  wire logic [7:0]   avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [31:0]  avs_writedata,
   input  wire logic [3:0]   avs_byteenable,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   output logic [1:0]        avs_response,
   // boot source
   input  wire logic         bootFromFlash,
   output logic              runBootRom,
   output logic              serialWatchEnable,
   output logic [15:0]       fetchStart,
   output logic              fetchStartValid,
   output logic [9:0]        bootRomLastAddr,
   // flash array
   output logic              flashReq,
   output logic [1:0]        flashOp,
   output logic [15:0]       flashAddr,
   output logic [7:0]        flashWdata,
   output logic              flashPulse,
   input  wire logic         flashAck,
   input  wire logic [7:0]   flashRdata
);

   // ************************************************************
   // storage
   // ************************************************************
   logic [7:0]               progAddressHigh;
   logic [7:0]               progAddressLow;
   logic [7:0]               progReadData;
   logic [7:0]               progWriteData;
   logic [7:0]               progPulseTiming;
   logic                     accessDone;
   logic [31:0]              next_readdata;
   logic [1:0]               next_response;
   logic                     cmdStart;
   isprg_pkg::isprg_op_e     cmdOp;
   logic [15:0]              seqAddr;
   logic                     runRom;
   logic [15:0]              startAddr;
   logic                     startValid;
   logic [15:0]              seqFlashAddr;
   isprg_pkg::isprg_op_e     seqFlashOp;
   logic                     seqFlashReq;
   logic [7:0]               seqFlashWdata;
   logic                     seqFlashPulse;
   logic                     wrHit;

   isprg_flash_if            flIf ();

   wire logic [15:0] progAddress = {progAddressHigh, progAddressLow};
   wire logic        busReq      = (avs_read | avs_write) & ~accessDone;

   // ************************************************************
   // bus handshake: one wait cycle, then answer
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         accessDone <= 1'b0;
      end else begin
         accessDone <= busReq;
      end
   end

   // waitrequest high while a request waits its answer cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~busReq;
      end
   end

   assign wrHit = avs_write & busReq & avs_byteenable[0];

   // ************************************************************
   // address registers
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         progAddressHigh <= `ISPRG_ADDR_RESET;
         progAddressLow  <= `ISPRG_ADDR_RESET;
      end else if (wrHit) begin
         if (avs_address == `ISPRG_OFF_ADDR_HIGH) begin
            progAddressHigh <= avs_writedata[7:0];
         end else if (avs_address == `ISPRG_OFF_ADDR_LOW) begin
            progAddressLow <= avs_writedata[7:0];
         end
      end
   end

   // write data has no reset: undetermined until loaded
   always_ff @(posedge clk_sys) begin
      if (wrHit && avs_address == `ISPRG_OFF_WRITE_DATA) begin
         progWriteData <= avs_writedata[7:0];
      end
   end

   // ************************************************************
   // pulse timing
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         progPulseTiming <= `ISPRG_TIMING_RESET;
      end else if (wrHit && avs_address == `ISPRG_OFF_PULSE_TIMING) begin
         progPulseTiming <= (avs_writedata[7:0] & `ISPRG_TIMING_WR_MASK)
                          | (progPulseTiming & ~`ISPRG_TIMING_WR_MASK);
      end
   end

   // ************************************************************
   // command: write to command offset starts an operation
   // ************************************************************
   // sequencer control kept internal
   always_comb begin
      cmdStart = wrHit && avs_address == `ISPRG_OFF_COMMAND && !flIf.busy;
      case (avs_writedata[1:0])
         `ISPRG_CMD_WRITE:      cmdOp = isprg_pkg::ISPRG_OP_WRITE;
         `ISPRG_CMD_PAGE_ERASE: cmdOp = isprg_pkg::ISPRG_OP_PAGE_ERASE;
         `ISPRG_CMD_MASS_ERASE: cmdOp = isprg_pkg::ISPRG_OP_MASS_ERASE;
         default:               cmdOp = isprg_pkg::ISPRG_OP_READ;
      endcase
   end

   always_comb begin
      if (progAddress == `ISPRG_OPTION_ALIAS) begin
         seqAddr = `ISPRG_OPTION_ADDR;
      end else begin
         seqAddr = progAddress;
      end
   end

   assign flIf.start  = cmdStart;
   assign flIf.op     = cmdOp;
   assign flIf.addr   = seqAddr;
   assign flIf.wdata  = progWriteData;
   assign flIf.timing = progPulseTiming;

   isprg_sequencer u_seq (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .fl         (flIf.seq),
      .flashReq   (seqFlashReq),
      .flashOp    (seqFlashOp),
      .flashAddr  (seqFlashAddr),
      .flashWdata (seqFlashWdata),
      .flashPulse (seqFlashPulse),
      .flashAck   (flashAck),
      .flashRdata (flashRdata)
   );

   // ************************************************************
   // read data: no reset, undefined until first read completes
   // ************************************************************
   logic lastWasRead;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lastWasRead <= 1'b0;
      end else if (cmdStart) begin
         lastWasRead <= (cmdOp == isprg_pkg::ISPRG_OP_READ);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (flIf.done && lastWasRead) begin
         progReadData <= flIf.rdata;
      end
   end

   // ************************************************************
   // read mux and response
   // ************************************************************
   always_comb begin
      next_readdata = 32'h0000_0000;
      next_response = 2'b00;
      if (avs_address == `ISPRG_OFF_ADDR_HIGH) begin
         next_readdata[7:0] = progAddressHigh;
      end else if (avs_address == `ISPRG_OFF_ADDR_LOW) begin
         next_readdata[7:0] = progAddressLow;
      end else if (avs_address == `ISPRG_OFF_READ_DATA) begin
         next_readdata[7:0] = progReadData;
      end else if (avs_address == `ISPRG_OFF_WRITE_DATA) begin
         next_readdata[7:0] = progWriteData;
      end else if (avs_address == `ISPRG_OFF_PULSE_TIMING) begin
         next_readdata[7:0] = progPulseTiming;
      end else if (avs_address == `ISPRG_OFF_COMMAND) begin
         next_readdata = 32'h0000_0000;
      end else if (avs_address == `ISPRG_OFF_STATUS) begin
         next_readdata[`ISPRG_STAT_BUSY]     = flIf.busy;
         next_readdata[`ISPRG_STAT_BOOT_ROM] = runRom;
      end else begin
         next_readdata = `ISPRG_UNMAPPED_DATA;
         next_response = 2'b10;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'b00;
      end else if (busReq) begin
         avs_readdata <= avs_read ? next_readdata : 32'h0000_0000;
         avs_response <= next_response;
      end
   end

   // ************************************************************
   // boot source
   // ************************************************************
   isprg_boot_select u_boot (
      .clk_sys       (clk_sys),
      .rst           (rst),
      .bootFromFlash (bootFromFlash),
      .runBootRom    (runRom),
      .startAddr     (startAddr),
      .startValid    (startValid)
   );

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         runBootRom        <= 1'b0;
         serialWatchEnable <= 1'b0;
         fetchStart        <= `ISPRG_RESET_VECTOR;
         fetchStartValid   <= 1'b0;
         bootRomLastAddr   <= 10'h000;
      end else begin
         runBootRom        <= runRom;
         serialWatchEnable <= runRom & startValid;
         fetchStart        <= startAddr;
         fetchStartValid   <= startValid;
         bootRomLastAddr   <= 10'(BOOT_ROM_BYTES - 1);
      end
   end

   // ************************************************************
   // flash port registered again so outputs come from flip-flops
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flashReq   <= 1'b0;
         flashOp    <= 2'b00;
         flashAddr  <= 16'h0000;
         flashWdata <= 8'h00;
         flashPulse <= 1'b0;
      end else begin
         flashReq   <= seqFlashReq & ~flashAck;
         flashOp    <= seqFlashOp;
         flashAddr  <= seqFlashAddr;
         flashWdata <= seqFlashWdata;
         flashPulse <= seqFlashPulse;
      end
   end

endmodule

// ==== testbench/isprg_regs_properties.sv ====
/*
 * checker of isprg_regs: bus answer timing, boot choice, flash port.
 * assumes it is bound to isprg_regs and sees only the block's ports.
 */
`timescale 1ns/1ps
`include "isprg_defs.svh"

module isprg_regs_properties #(
   parameter int BOOT_ROM_BYTES = `ISPRG_BOOT_ROM_BYTES
) (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // avalon-mm slave
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  avs_response,
   // boot source
   input wire logic        bootFromFlash,
   input wire logic        runBootRom,
   input wire logic        serialWatchEnable,
   input wire logic [15:0] fetchStart,
   input wire logic        fetchStartValid,
   input wire logic [9:0]  bootRomLastAddr,
   // flash array
   input wire logic        flashReq,
   input wire logic [1:0]  flashOp,
   input wire logic [15:0] flashAddr,
   input wire logic [7:0]  flashWdata,
   input wire logic        flashPulse
);
   // ********************
   // shadow of the software-written registers
   // ********************
   logic [7:0]  aHi, aLo, wDat, tim;
   logic [15:0] pCnt, expAddr;
   logic        wrOk;
   assign wrOk = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign expAddr = ({aHi, aLo} == `ISPRG_OPTION_ALIAS) ? `ISPRG_OPTION_ADDR : {aHi, aLo};
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aHi <= 8'h00;
         aLo <= 8'h00;
         tim <= `ISPRG_TIMING_RESET;
      end else if (wrOk) begin
         case (avs_address)
            8'h00: aHi <= avs_writedata[7:0];
            8'h04: aLo <= avs_writedata[7:0];
            8'h0c: wDat <= avs_writedata[7:0];
            8'h10: tim <= avs_writedata[7:0] & `ISPRG_TIMING_WR_MASK;
            default: ;
         endcase
      end
   end
   // length of the current pulse; 16 bits cover the largest code
   always_ff @(posedge clk_sys) begin
      pCnt <= flashPulse ? pCnt + 16'h0001 : 16'h0000;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_ANSWER_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer lasted more than one cycle");
   AST_ANSWER_SOON: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
      else $error("answer late");
   AST_RD_UPPER: assert property (!avs_waitrequest && avs_read && avs_response == 2'h0
      |-> avs_readdata[31:8] == 24'h000000) else $error("read data upper bits not zero");
   AST_UNMAPPED: assert property (!avs_waitrequest && avs_read && avs_response == 2'h2
      |-> avs_readdata == `ISPRG_UNMAPPED_DATA) else $error("unmapped read data wrong");
   AST_BOOT_SRC: assert property (fetchStartValid |-> runBootRom == !bootFromFlash)
      else $error("boot source wrong");
   AST_FETCH_START: assert property (fetchStartValid |-> fetchStart == `ISPRG_RESET_VECTOR)
      else $error("fetch start not 0000");
   AST_SERIAL_WATCH: assert property (fetchStartValid |-> serialWatchEnable == runBootRom)
      else $error("serial watch wrong");
   AST_ROM_SIZE: assert property (fetchStartValid |-> bootRomLastAddr == BOOT_ROM_BYTES - 1)
      else $error("boot rom size wrong");
   AST_PULSE_LEN: assert property ($fell(flashPulse)
      |-> pCnt == 16'((int'(tim[6:0]) + 1) * `ISPRG_STEP_CYCLES)) else $error("pulse length wrong");
   AST_FL_ADDR: assert property (flashReq |-> flashAddr == expAddr)
      else $error("flash address wrong");
   AST_FL_WDATA: assert property (flashReq && flashOp == `ISPRG_CMD_WRITE |-> flashWdata == wDat)
      else $error("flash byte wrong");
   AST_PULSE_OP: assert property (flashPulse |-> flashOp != `ISPRG_CMD_READ)
      else $error("pulse during read");

   COV_PULSE: cover property ($fell(flashPulse));
   COV_UNMAPPED: cover property (!avs_waitrequest && avs_response == 2'h2);
   COV_OPTION: cover property (flashReq && flashAddr == `ISPRG_OPTION_ADDR);
endmodule

bind isprg_regs isprg_regs_properties #(.BOOT_ROM_BYTES(BOOT_ROM_BYTES)) i_props (
   .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .avs_response, .bootFromFlash, .runBootRom,
   .serialWatchEnable, .fetchStart, .fetchStartValid, .bootRomLastAddr, .flashReq, .flashOp,
   .flashAddr, .flashWdata, .flashPulse);

// ==== testbench/isprg_flash_model.sv ====
/*
 * behavioural flash array: answers each request once, promptly or slowly.
 * assumes requests are held until acknowledged; erased bytes read ff.
 */
`timescale 1ns/1ps

module isprg_flash_model #(
   parameter logic [7:0] OPT_BYTE   = 8'h5a,
   parameter int         PAGE_BYTES = 64
) (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // flash port
   input wire logic        flashReq,
   input wire logic [1:0]  flashOp,
   input wire logic [15:0] flashAddr,
   input wire logic [7:0]  flashWdata,
   output logic            flashAck,
   output logic [7:0]      flashRdata,
   // pacing
   input wire logic        slowAck
);
   logic [7:0] mem [logic [15:0]];
   int         waitN;
   logic       served;
   initial mem[16'h1fff] = OPT_BYTE;
   initial flashRdata = 8'h00;
   always @(posedge clk_sys) begin
      flashAck <= 1'b0;
      // data toggles outside answers so a stale sample shows
      flashRdata <= ~flashRdata;
      if (rst || !flashReq) begin
         served <= 1'b0;
         waitN = 0;
      end else if (!served && waitN < (slowAck ? 4 : 1)) begin
         waitN++;
      end else if (!served) begin
         served <= 1'b1;
         flashAck <= 1'b1;
         case (flashOp)
            2'h0: flashRdata <= mem.exists(flashAddr) ? mem[flashAddr] : 8'hff;
            2'h1: mem[flashAddr] = flashWdata;
            2'h2: for (int i = 0; i < PAGE_BYTES; i++) mem.delete(16'(flashAddr + i));
            default: mem.delete();
         endcase
      end
   end
endmodule

// ==== testbench/isprg_regs_tb.sv ====
/*
 * testbench of isprg_regs: register access, flash operations, boot choice.
 * assumes the flash model on the array port and the bound checker.
 */
`timescale 1ns/1ps
`include "isprg_defs.svh"

module isprg_regs_tb;
   logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address, flashWdata, flashRdata;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable;
   logic [1:0]  avs_response, flashOp, rs;
   logic        bootFromFlash, runBootRom, serialWatchEnable, fetchStartValid;
   logic [15:0] fetchStart, flashAddr;
   logic [9:0]  bootRomLastAddr;
   logic        flashReq, flashPulse, flashAck, slowAck;
   int          n_fail = 0;
   int          samples_checked = 0;

   isprg_regs i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .bootFromFlash,
      .runBootRom, .serialWatchEnable, .fetchStart, .fetchStartValid, .bootRomLastAddr,
      .flashReq, .flashOp, .flashAddr, .flashWdata, .flashPulse, .flashAck, .flashRdata);
   isprg_flash_model i_flash (.clk_sys, .rst, .flashReq, .flashOp, .flashAddr, .flashWdata,
      .flashAck, .flashRdata, .slowAck);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ********************
   // bus and compare tasks
   // ********************
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   // no cycle count assumed: only the watchdog ends a hang
   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] be);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      rs = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, 4'hf);
   endtask
   task automatic ad(logic [15:0] a);
      wr(8'h00, a[15:8]);
      wr(8'h04, a[7:0]);
   endtask
   task automatic rdchk(string nm, logic [7:0] a, logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(nm, e, rd);
   endtask
   task automatic op(logic [1:0] o);
      int n = 0;
      wr(8'h14, {6'h0, o});
      do begin
         bus(1'b0, 8'h18, 32'h0, 4'hf);
         n++;
      end while (rd[0] !== 1'b0 && n < 1000);
      if (n >= 1000) chk("busy", 32'h0, 32'h1);
   endtask

   // ********************
   // sequence
   // ********************
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
      {bootFromFlash, slowAck} = 2'b00;
      rst = 1'b1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("runBootRom", 32'h1, 32'(runBootRom));
      chk("serialWatch", 32'h1, 32'(serialWatchEnable));
      chk("romLast", 32'h3ff, 32'(bootRomLastAddr));
      rdchk("addrHigh", 8'h00, 32'h0);
      rdchk("addrLow", 8'h04, 32'h0);
      rdchk("timing", 8'h10, 32'h7b);
      rdchk("status", 8'h18, 32'h2);
      rdchk("hidden", 8'h1c, `ISPRG_UNMAPPED_DATA);
      chk("response", 32'h2, 32'(rs));
      ad(16'h1234);
      wr(8'h0c, 8'ha5);
      op(`ISPRG_CMD_WRITE);
      wr(8'h10, 8'hff);
      rdchk("timingRo", 8'h10, 32'h7f);
      bus(1'b1, 8'h10, 32'h0, 4'h0);
      rdchk("timingLane", 8'h10, 32'h7f);
      wr(8'h10, 8'h01);
      op(`ISPRG_CMD_READ);
      rdchk("readBack", 8'h08, 32'ha5);
      ad(16'hffff);
      op(`ISPRG_CMD_READ);
      rdchk("option", 8'h08, 32'h5a);
      slowAck <= 1'b1;
      ad(16'h1200);
      op(`ISPRG_CMD_PAGE_ERASE);
      wr(8'h04, 8'h34);
      op(`ISPRG_CMD_READ);
      rdchk("pageErase", 8'h08, 32'hff);
      wr(8'h0c, 8'h3c);
      op(`ISPRG_CMD_WRITE);
      ad(16'h0000);
      op(`ISPRG_CMD_MASS_ERASE);
      ad(16'h1234);
      op(`ISPRG_CMD_READ);
      rdchk("massErase", 8'h08, 32'hff);
      // programming done: reset, with the option bit set in the same cycle
      rst <= 1'b1;
      bootFromFlash <= 1'b1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("runFlash", 32'h0, 32'(runBootRom));
      chk("fetchStart", 32'h0, 32'(fetchStart));
      chk("fetchValid", 32'h1, 32'(fetchStartValid));
      chk("serialOff", 32'h0, 32'(serialWatchEnable));
      rdchk("statusFlash", 8'h18, 32'h0);
      conclude();
   end

   // run needs well under 20k cycles
   initial begin
      #200000;
      n_fail++;
      conclude();
   end
endmodule
